// ---- hw/bt_mark_space_timer.sv ----
// Mark/space bit timer: transmit keying, receive edge timing and a generic
// countdown, reached through two byte registers in processor I/O space.
// Assumes clk is the crystal clock and edgeInputPin is already synchronous.
`default_nettype none

// How it works
// - Count value is low register plus control bits 7:6 on top.
// - Each mark or space lasts count value plus one processor clocks.
// - Mode field 5:4 picks off, generic, receive or transmit.
// - With enable bit 3 set, each flag raises its own interrupt.
// - Buffer flag vectors to 0x04, done flag vectors to 0x02.
// - Transmit and generic set done once buffer empty and count at zero.
// - Receive sets done on each pin edge; flag held low when disabled.
// - Reading the control register clears both flags.
// - Timer taking the buffered bit sets the buffer flag; software refills.
// - Receive data bit shows last edge polarity, one rising, zero falling.
// - Receive count value holds processor clocks since previous edge.
// - Receive counter overflow sets buffer flag; software extends count.
// - Processor clock is crystal divided by 16, 32, 64 or 128.
module bt_mark_space_timer
	import bt_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [1:0] cpuClockDividerSel,
	input wire logic [7:0] ioAddr,
	input wire logic ioWrite,
	input wire logic ioRead,
	input wire logic [7:0] ioWriteData,
	output logic [7:0] ioReadData,
	input wire logic edgeInputPin,
	output logic txKey,
	output logic doneIrq,
	output logic bufferIrq
);
	import bt_pkg::*;

	typedef struct packed {
		logic [7:0] countLow;
		logic [1:0] countHi;
		bt_mode_t mode;
		logic irqEnable;
		logic doneFlag;
		logic dataBit;
		logic bufFlag;
		logic bufFull;
		logic running;
		logic [COUNT_W-1:0] cnt;
		logic edgePrev;
		logic txKey;
		logic doneIrq;
		logic bufIrq;
		logic [7:0] readData;
	} bt_state_t;

	bt_state_t state_reg;
	bt_state_t state_next;
	bt_tick_if tickBus ();

	// ----------------------------------------
	// Processor clock prescaler
	// ----------------------------------------
	assign tickBus.divSel = cpuClockDividerSel;

	bt_clock_divider u_bt_clock_divider (
		.clk(clk),
		.reset(reset),
		.tickBus(tickBus)
	);

	// ----------------------------------------
	// Register view and decode
	// ----------------------------------------
	logic [7:0] controlView;
	logic [COUNT_W-1:0] countVal;
	logic wrLow;
	logic wrCtl;
	logic rdCtl;
	logic edgeSeen;
	logic doneSet;
	logic bufSet;

	always_comb begin
		controlView = {state_reg.countHi, state_reg.mode, state_reg.irqEnable,
			state_reg.doneFlag, state_reg.dataBit, state_reg.bufFlag};
		countVal = {state_reg.countHi, state_reg.countLow};
		wrLow = ioWrite && (ioAddr == MARK_SPACE_COUNT_LOW_OFS);
		wrCtl = ioWrite && (ioAddr == BIT_TIMER_CONTROL_STATUS_OFS);
		rdCtl = ioRead && (ioAddr == BIT_TIMER_CONTROL_STATUS_OFS);
		edgeSeen = (edgeInputPin != state_reg.edgePrev);
	end

	// ----------------------------------------
	// Timer core: all modes in one next-state process
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		doneSet = 1'b0;
		bufSet = 1'b0;
		state_next.edgePrev = edgeInputPin;

		// Software writes first; hardware events below take precedence, except a buffer fill written at a bit boundary
		if (wrLow) begin
			state_next.countLow = ioWriteData;
		end
		if (wrCtl) begin
			state_next.countHi = ioWriteData[COUNT_HI_MSB:COUNT_HI_LSB];
			state_next.mode = bt_mode_t'(ioWriteData[MODE_MSB:MODE_LSB]);
			state_next.irqEnable = ioWriteData[IRQ_ENABLE_BIT];
			state_next.dataBit = ioWriteData[DATA_BIT];
			if (ioWriteData[MODE_MSB:MODE_LSB] != state_reg.mode) begin
				// Mode switch restarts the counter from a known point
				state_next.cnt = '0;
				state_next.running = 1'b0;
				state_next.bufFull = 1'b0;
			end
			if (ioWriteData[MODE_LSB]) begin
				// Generic or transmit: a data write fills the one-bit buffer
				state_next.bufFull = 1'b1;
				state_next.running = 1'b1;
			end
		end

		case (state_reg.mode)
			BT_MODE_GENERIC, BT_MODE_TX: begin
				if (tickBus.tick && state_reg.running) begin
					if (state_reg.cnt != '0) begin
						state_next.cnt = state_reg.cnt - 1'b1;
					end else if (state_reg.bufFull) begin
						// Bit boundary: take bit, reload count
						state_next.bufFull = wrCtl && ioWriteData[MODE_LSB];
						state_next.cnt = countVal;
						bufSet = 1'b1;
						if (state_reg.mode == BT_MODE_TX) begin
							state_next.txKey = state_reg.dataBit;
						end
					end else begin
						// Buffer empty and count expired
						doneSet = 1'b1;
						state_next.running = 1'b0;
						state_next.txKey = 1'b0;
					end
				end
			end
			BT_MODE_RX: begin
				if (edgeSeen) begin
					// Capture elapsed clocks, then restart from zero
					state_next.countLow = state_reg.cnt[7:0];
					state_next.countHi = state_reg.cnt[COUNT_W-1:8];
					state_next.dataBit = edgeInputPin;
					state_next.cnt = '0;
					doneSet = 1'b1;
				end else if (tickBus.tick) begin
					state_next.cnt = state_reg.cnt + 1'b1;
					if (&state_reg.cnt) begin
						bufSet = 1'b1;
					end
				end
			end
			BT_MODE_OFF: begin
				state_next.txKey = 1'b0;
				// Entering off already stopped the timer; a start write must survive
			end
			default: begin
				state_next.txKey = 1'b0;
			end
		endcase

		// Read clears flags; a same-cycle set survives the clear
		if (rdCtl) begin
			state_next.doneFlag = 1'b0;
			state_next.bufFlag = 1'b0;
		end
		if (doneSet) begin
			state_next.doneFlag = 1'b1;
		end
		if (bufSet) begin
			state_next.bufFlag = 1'b1;
		end
		if (state_next.mode == BT_MODE_OFF) begin
			state_next.doneFlag = 1'b0;
		end

		// Separate request lines; done at 0x02, buffer at 0x04
		state_next.doneIrq = state_next.doneFlag && state_next.irqEnable;
		state_next.bufIrq = state_next.bufFlag && state_next.irqEnable;

		// Read data is the value before the read's own clear
		if (ioRead) begin
			if (ioAddr == MARK_SPACE_COUNT_LOW_OFS) begin
				state_next.readData = state_reg.countLow;
			end else if (rdCtl) begin
				state_next.readData = controlView;
			end else begin
				state_next.readData = REG_RESET;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------
	// Outputs straight from the state register
	// ----------------------------------------
	assign ioReadData = state_reg.readData;
	assign txKey = state_reg.txKey;
	assign doneIrq = state_reg.doneIrq;
	assign bufferIrq = state_reg.bufIrq;

endmodule // bt_mark_space_timer

`default_nettype wire

// ---- hw/bt_pkg.sv ----
// Constants for the mark/space bit timer: register offsets, field layout,
// modes and prescaler settings.
// Assumes a processor I/O bus with byte-wide registers at fixed addresses.
`default_nettype none

package bt_pkg;

	// ----------------------------------------
	// Register offsets in I/O space
	// ----------------------------------------
	localparam logic [7:0] MARK_SPACE_COUNT_LOW_OFS = 8'h20;
	localparam logic [7:0] BIT_TIMER_CONTROL_STATUS_OFS = 8'h21;
	localparam logic [7:0] REG_RESET = 8'h00;

	// ----------------------------------------
	// Control/status field positions
	// ----------------------------------------
	localparam int COUNT_HI_MSB = 7;
	localparam int COUNT_HI_LSB = 6;
	localparam int MODE_MSB = 5;
	localparam int MODE_LSB = 4;
	localparam int IRQ_ENABLE_BIT = 3;
	localparam int DONE_FLAG_BIT = 2;
	localparam int DATA_BIT = 1;
	localparam int BUF_FLAG_BIT = 0;

	// ----------------------------------------
	// Count width and interrupt vectors
	// ----------------------------------------
	localparam int COUNT_W = 10;
	localparam logic [7:0] BUF_IRQ_VECTOR = 8'h04;
	localparam logic [7:0] DONE_IRQ_VECTOR = 8'h02;

	// ----------------------------------------
	// Timer modes
	// ----------------------------------------
	typedef enum logic [1:0] {
		BT_MODE_OFF = 2'h0,
		BT_MODE_GENERIC = 2'h1,
		BT_MODE_RX = 2'h2,
		BT_MODE_TX = 2'h3
	} bt_mode_t;

	// ----------------------------------------
	// Prescaler: crystal clock cycles per timer tick, minus one
	// ----------------------------------------
	localparam int DIV_W = 7;
	localparam logic [DIV_W-1:0] DIV16_LAST = 7'h0F;
	localparam logic [DIV_W-1:0] DIV32_LAST = 7'h1F;
	localparam logic [DIV_W-1:0] DIV64_LAST = 7'h3F;
	localparam logic [DIV_W-1:0] DIV128_LAST = 7'h7F;

endpackage

`default_nettype wire

// ---- hw/bt_tick_if.sv ----
// Interface carrying the processor-clock tick from the prescaler to the timer.
// Assumes both ends sit in the crystal clock domain.
`default_nettype none

interface bt_tick_if;
	logic tick;
	logic [1:0] divSel;

	modport src (input divSel, output tick);
	modport dst (output divSel, input tick);
endinterface

`default_nettype wire

// ---- hw/bt_clock_divider.sv ----
// Prescaler that turns the crystal clock into processor-clock ticks.
// Assumes the select may change at any time; a change takes effect at the
// next wrap or at once if the count is already past the new limit.
`default_nettype none

module bt_clock_divider
	import bt_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	bt_tick_if.src tickBus
);

	typedef struct packed {
		logic [DIV_W-1:0] count;
		logic tick;
	} bt_div_state_t;

	bt_div_state_t state_reg;
	bt_div_state_t state_next;
	logic [DIV_W-1:0] lastCount;

	// ----------------------------------------
	// Divide ratio select
	// ----------------------------------------
	always_comb begin
		case (tickBus.divSel)
			2'h3: lastCount = DIV16_LAST;
			2'h2: lastCount = DIV32_LAST;
			2'h1: lastCount = DIV64_LAST;
			default: lastCount = DIV128_LAST;
		endcase
	end

	// Free-running count; >= guards against a shrinking ratio
	always_comb begin
		state_next = state_reg;
		state_next.tick = 1'b0;
		if (state_reg.count >= lastCount) begin
			state_next.count = '0;
			state_next.tick = 1'b1;
		end else begin
			state_next.count = state_reg.count + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign tickBus.tick = state_reg.tick;

endmodule // bt_clock_divider

`default_nettype wire

// ---- tb/bt_edge_source.sv ----
// Far-side model: a source of edges on the receive pin.
// Assumes the timer clock; the pin moves only after a falling edge.
`default_nettype none
module bt_edge_source (
	input wire logic clk,
	output logic pinLevel
);
	timeunit 1ns;
	timeprecision 1ps;
	// Starts low, so the first flip is a rising edge
	initial pinLevel = 1'b0;
	// Off the sampling edge, so the timer never sees a half-changed pin
	task automatic flip();
		@(negedge clk);
		pinLevel = ~pinLevel;
	endtask
endmodule // bt_edge_source
`default_nettype wire

// ---- tb/bt_timer_properties.sv ----
// Port checker for the mark/space bit timer.
// Assumes a bind onto the timer top; one clock, synchronous reset.
`default_nettype none
module bt_timer_properties
	import bt_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [7:0] ioAddr,
	input wire logic ioWrite,
	input wire logic ioRead,
	input wire logic [7:0] ioReadData,
	input wire logic txKey,
	input wire logic doneIrq,
	input wire logic bufferIrq
);
	logic ctlHit, ctlRd, offMap;
	// ----
	// Helpers
	// ----
	// Only a control access may clear a flag or its enable
	assign ctlHit = (ioRead | ioWrite) && ioAddr == BIT_TIMER_CONTROL_STATUS_OFS;
	assign ctlRd = ioRead && ioAddr == BIT_TIMER_CONTROL_STATUS_OFS;
	assign offMap = ioAddr != MARK_SPACE_COUNT_LOW_OFS && !ctlHit;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// ----
	// Properties
	// ----
	unmapped_read_a: assert property (ioRead && offMap |=> ioReadData == REG_RESET)
		else $error("unmapped read not zero");
	read_hold_a: assert property (!ioRead |=> $stable(ioReadData))
		else $error("read data moved without a read");
	key_hold_a: assert property ($changed(txKey) |=> $stable(txKey) [*8])
		else $error("key bit shorter than one tick");
	buf_hold_a: assert property (bufferIrq && !ctlHit |=> bufferIrq)
		else $error("buffer request dropped without read");
	done_hold_a: assert property (doneIrq && !ctlHit |=> doneIrq)
		else $error("done request dropped without read");
	rd_done_a: assert property (ctlRd && doneIrq |=> ioReadData[DONE_FLAG_BIT]
		&& ioReadData[IRQ_ENABLE_BIT]) else $error("done request without flag");
	rd_buf_a: assert property (ctlRd && bufferIrq |=> ioReadData[BUF_FLAG_BIT]
		&& ioReadData[IRQ_ENABLE_BIT]) else $error("buffer request without flag");
	done_key_a: assert property ($rose(doneIrq) |-> !txKey)
		else $error("key still high at done");
endmodule // bt_timer_properties
`default_nettype wire

// ---- tb/test_bt_mark_space_timer.sv ----
// Bench for the bit timer: registers, transmit and generic timing, receive.
// Assumes a 200 MHz clock and the edge source on the receive pin.
`default_nettype none
module test_bt_mark_space_timer;
	import bt_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, reset = 1, ioWrite = 0, ioRead = 0, rdSeen = 0;
	logic txKey, doneIrq, bufferIrq, pin;
	logic [1:0] sel = 2'h3;
	logic [7:0] ioAddr = 8'h00, ioWriteData = 8'h00, ioReadData;
	logic [15:0] expQ[$];
	logic [15:0] note;
	int fail_count = 0, n_tests = 0, cyc = 0, tRef, ta, tb, k;
	localparam logic [7:0] LO = MARK_SPACE_COUNT_LOW_OFS, CT = BIT_TIMER_CONTROL_STATUS_OFS;
	always #2.5 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;
	bt_mark_space_timer u_bt_mark_space_timer (.clk(clk), .reset(reset),
		.cpuClockDividerSel(sel), .ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead),
		.ioWriteData(ioWriteData), .ioReadData(ioReadData), .edgeInputPin(pin),
		.txKey(txKey), .doneIrq(doneIrq), .bufferIrq(bufferIrq));
	bt_edge_source u_bt_edge_source (.clk(clk), .pinLevel(pin));
	// ----
	// Checking
	// ----
	task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Read data lands the cycle after the strobe; oldest note first
	always @(posedge clk) begin
		if (rdSeen && expQ.size() > 0) begin
			note = expQ.pop_front();
			chk("read data", note[7:0], ioReadData & note[15:8]);
		end
		rdSeen <= ioRead;
	end
	// ----
	// Bus tasks
	// ----
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(negedge clk);
		ioAddr = a;
		ioWriteData = d;
		ioWrite = 1;
		@(negedge clk);
		ioWrite = 0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e, logic [7:0] m = 8'hFF);
		@(negedge clk);
		ioAddr = a;
		ioRead = 1;
		expQ.push_back({m, e & m});
		@(negedge clk);
		ioRead = 0;
	endtask
	// Bounded wait for one request line; a miss counts as a mismatch
	task automatic waitHi(logic w, output int t);
		for (int i = 0; i < 20000 && (w ? doneIrq : bufferIrq) !== 1'b1; i++)
			@(negedge clk);
		chk("request seen", 1, w ? doneIrq : bufferIrq);
		t = cyc;
	endtask
	// One mark, one space, then done; every span is (count+1) ticks
	task automatic txRun(logic [1:0] hi, logic [7:0] lo, logic [1:0] m, logic [1:0] s);
		logic [7:0] c;
		int len;
		c = {hi, m, 4'h8};
		len = ({hi, lo} + 1) * (16 << (3 - s));
		sel = s;
		wr(LO, lo);
		wr(CT, c | 8'h02);
		waitHi(0, ta);
		chk("key mark", m[1], txKey);
		rd(CT, c | 8'h03);
		wr(CT, c);
		waitHi(0, tb);
		chk("bit span", len, tb - ta);
		chk("key space", 0, txKey);
		rd(CT, c | 8'h01);
		waitHi(1, ta);
		chk("done span", len, ta - tb);
		rd(CT, c | 8'h04);
		rd(CT, c);
		tRef = tb;
	endtask
	// ----
	// Sequence
	// ----
	initial begin
		void'($urandom(46));
		repeat (6) @(negedge clk);
		reset = 0;
		k = $urandom_range(255, 1);
		rd(LO, REG_RESET);
		rd(CT, REG_RESET);
		wr(8'h22, 8'hFF);
		wr(LO, k[7:0]);
		rd(LO, k[7:0]);
		rd(8'h22, REG_RESET);
		// Disabled: pin edges and flag writes leave no trace
		wr(CT, 8'hCD);
		u_bt_edge_source.flip();
		repeat (4) @(negedge clk);
		chk("done while off", 0, doneIrq);
		rd(CT, 8'hC8);
		txRun(2'h0, 8'($urandom_range(15, 1)), 2'h1, 2'($urandom_range(2, 0)));
		txRun(2'h1, 8'h02, 2'h3, 2'h3);
		// Receive: place edges half a tick away from the tick phase
		wr(CT, 8'h28);
		while ((cyc + 2 - tRef) % 16 != 8) @(negedge clk);
		tb = cyc;
		u_bt_edge_source.flip();
		waitHi(1, ta);
		rd(CT, 8'h2C, 8'h3F);
		k = $urandom_range(30, 2);
		while (cyc != tb + 16 * k) @(negedge clk);
		tb = cyc;
		u_bt_edge_source.flip();
		waitHi(1, ta);
		rd(LO, k[7:0]);
		rd(CT, 8'h2E);
		waitHi(0, ta);
		chk("overflow span", 1, ta >= tb + 16368 && ta <= tb + 16400);
		rd(CT, 8'h2B);
		// Enable off: the flag still sets, the request line stays low
		wr(CT, 8'h20);
		u_bt_edge_source.flip();
		repeat (4) @(negedge clk);
		chk("done masked", 0, doneIrq);
		rd(CT, 8'h24, 8'h3F);
		test_done();
	end
	// Whole run needs about 25k to 30k cycles
	initial begin
		#300000;
		fail_count++;
		test_done();
	end
endmodule // test_bt_mark_space_timer
bind bt_mark_space_timer bt_timer_properties u_bt_timer_properties (.clk(clk), .reset(reset),
	.ioAddr(ioAddr), .ioWrite(ioWrite), .ioRead(ioRead), .ioReadData(ioReadData),
	.txKey(txKey), .doneIrq(doneIrq), .bufferIrq(bufferIrq));
`default_nettype wire
